/* csd_card_model.sv */
`default_nettype none
module csd_card_model (
  input wire logic clk,
  input wire logic card_supply_on,
  input wire logic fail,
  input wire logic inserted,
  output logic card_supply_good_in,
  output logic card_detect_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Card supply and slot switch
  // ----
  // Supply needs a few clocks to settle; a fault drops good at once
  logic [2:0] ramp = 3'h0;
  always_ff @(posedge clk)
    ramp <= card_supply_on ? ramp + 3'(ramp != 3'h7) : 3'h0;
  assign card_supply_good_in = card_supply_on && ramp == 3'h7 && !fail;
  assign card_detect_pin = inserted;
endmodule
`default_nettype wire

/* csd_cfg.svh */
// Behaviour
// - Non-zero supply select write starts activation
// - Card event or supply loss deactivates
// - Core fault clears flag and select
// - Ready mode waits good; else expiry deactivates
// - Supply good bit is read only
// - Chip power off bit drives power off
// - Supply not good at expiry: event, deactivate
// - Settle field counts 32768 Hz periods
// - Settle value zero disables timeout
// - Off delay field delays normal deactivation
// - Emergency deactivation skips off delay
// - Unfiltered presence while power down set
// - Filter needs 64 ms stable, clears immediately
// - Detect enable activates input, resets zero
// - Polarity selects pin level meaning present
// - Pull-up enable low, pull-down enable high
// - Presence read only; change is card event
// - Card event flag, cleared by status read
// - Settle expiry flag, cleared by status read
`ifndef CSD_CFG_SVH
`define CSD_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CSD_ADDR_INT_STATUS 16'hfe01
`define CSD_ADDR_SUPPLY_CTRL 16'hfe03
`define CSD_ADDR_SUPPLY_TMR 16'hfe04
`define CSD_ADDR_DETECT_CTRL 16'hfe05
`define CSD_ADDR_AUX_CTRL 16'hfe10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSD_SEL_HI 7
`define CSD_SEL_LO 6
`define CSD_FAULT_BIT 5
`define CSD_READY_BIT 4
`define CSD_GOOD_BIT 3
`define CSD_PWROFF_BIT 0
`define CSD_OFFDLY_HI 7
`define CSD_OFFDLY_LO 4
`define CSD_SETTLE_HI 3
`define CSD_SETTLE_LO 0
`define CSD_FILT_BIT 7
`define CSD_DETEN_BIT 6
`define CSD_POL_BIT 3
`define CSD_PU_BIT 2
`define CSD_PD_BIT 1
`define CSD_PRESENT_BIT 0
`define CSD_EVFLAG_BIT 6
`define CSD_TOFLAG_BIT 5
`define CSD_PDBIT_BIT 0

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CSD_RST_OFFDLY 4'h0
`define CSD_RST_SETTLE 4'hf
`define CSD_ZERO2 2'h0
`define CSD_ZERO4 4'h0
`define CSD_ZERO7 7'h00
`define CSD_ZERO8 8'h00
`define CSD_ONE4 4'h1
`define CSD_ONE7 7'h01
`define CSD_DEBOUNCE_MS 64
`define CSD_TICK_PER_MS 1
`define CSD_DEBOUNCE_TICKS \
  (7'(`CSD_DEBOUNCE_MS * `CSD_TICK_PER_MS))

// Synchroniser lanes
`define CSD_S_T32 0
`define CSD_S_T1K 1
`define CSD_S_GOOD 2
`define CSD_S_FAULT 3
`define CSD_S_READY 4
`define CSD_S_DET 5

`endif

/* csd_pkg.sv */
`default_nettype none
package csd_pkg;

  typedef enum logic [2:0] {
    CSD_IDLE = 3'b000,
    CSD_SETTLE = 3'b001,
    CSD_ACTIVE = 3'b010,
    CSD_OFF_DELAY = 3'b011,
    CSD_DEACT_RST = 3'b100,
    CSD_DEACT_CLK = 3'b101,
    CSD_DEACT_IO = 3'b110,
    CSD_SUPPLY_OFF = 3'b111
  } csd_state_type;

  typedef struct packed {
    csd_state_type state;
    logic [1:0] sel;
    logic [1:0] level;
    logic fault_arm;
    logic ready_mode;
    logic pwr_off;
    logic [3:0] off_dly;
    logic [3:0] settle_to;
    logic filt_en;
    logic det_en;
    logic det_pol;
    logic pu_n;
    logic pd_en;
    logic pd_bit;
    logic [3:0] cnt;
    logic present;
    logic [6:0] deb;
    logic ev_flag;
    logic to_flag;
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [7:0] rdata;
  } csd_regs_type;

endpackage
`default_nettype wire

/* csd_top.sv */
`include "csd_cfg.svh"
`default_nettype none
module csd_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tick_32k,
  input wire logic tick_1k,
  input wire logic card_supply_good_in,
  input wire logic core_fault_in,
  input wire logic external_ready,
  input wire logic card_detect_pin,
  output logic [1:0] card_supply_level,
  output logic card_supply_on,
  output logic card_rst_n,
  output logic card_clk_enable,
  output logic card_io_enable,
  output logic chip_power_off,
  output logic pullup_enable_n,
  output logic pulldown_enable,
  output logic card_present
);

  csd_pkg::csd_regs_type r;
  csd_pkg::csd_regs_type next_r;

  logic t32;
  logic t1k;
  logic good;
  logic fault;
  logic rdy;
  logic raw;
  logic wr_ctrl;
  logic wr_tmr;
  logic wr_det;
  logic wr_aux;
  logic rd_int;
  logic card_event;
  logic fault_hit;
  logic emergency;
  logic settle_fail;
  logic expired;
  logic [7:0] rd_val;

  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  // Edge detect only on the second stage, never the first
  assign t32 = r.s2[`CSD_S_T32] & ~r.s3[`CSD_S_T32];
  assign t1k = r.s2[`CSD_S_T1K] & ~r.s3[`CSD_S_T1K];
  assign good = r.s2[`CSD_S_GOOD];
  assign fault = r.s2[`CSD_S_FAULT];
  assign rdy = r.s2[`CSD_S_READY];
  // Presence level after polarity and enable
  assign raw = r.det_en &
      (r.det_pol ? r.s2[`CSD_S_DET] :
       ~r.s2[`CSD_S_DET]);

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  assign wr_ctrl = reg_wr & (reg_addr == `CSD_ADDR_SUPPLY_CTRL);
  assign wr_tmr = reg_wr & (reg_addr == `CSD_ADDR_SUPPLY_TMR);
  assign wr_det = reg_wr & (reg_addr == `CSD_ADDR_DETECT_CTRL);
  assign wr_aux = reg_wr & (reg_addr == `CSD_ADDR_AUX_CTRL);
  assign rd_int = reg_rd & (reg_addr == `CSD_ADDR_INT_STATUS);

  // ----------------------------------------
  // Sequencer conditions
  // ----------------------------------------
  assign fault_hit = r.fault_arm & fault;
  assign expired = (r.settle_to != `CSD_ZERO4) & t32 &
      (r.cnt == `CSD_ONE4);
  assign settle_fail = expired & ~good;

  always_comb begin
    rd_val = `CSD_ZERO8;
    case (reg_addr)
      `CSD_ADDR_INT_STATUS: begin
        rd_val[`CSD_EVFLAG_BIT] = r.ev_flag;
        rd_val[`CSD_TOFLAG_BIT] = r.to_flag;
      end
      `CSD_ADDR_SUPPLY_CTRL: begin
        rd_val[`CSD_SEL_HI:`CSD_SEL_LO] = r.sel;
        rd_val[`CSD_FAULT_BIT] = r.fault_arm;
        rd_val[`CSD_READY_BIT] = r.ready_mode;
        rd_val[`CSD_GOOD_BIT] = good;
        rd_val[`CSD_PWROFF_BIT] = r.pwr_off;
      end
      `CSD_ADDR_SUPPLY_TMR: begin
        rd_val[`CSD_OFFDLY_HI:`CSD_OFFDLY_LO] = r.off_dly;
        rd_val[`CSD_SETTLE_HI:`CSD_SETTLE_LO] = r.settle_to;
      end
      `CSD_ADDR_DETECT_CTRL: begin
        rd_val[`CSD_FILT_BIT] = r.filt_en;
        rd_val[`CSD_DETEN_BIT] = r.det_en;
        rd_val[`CSD_POL_BIT] = r.det_pol;
        rd_val[`CSD_PU_BIT] = r.pu_n;
        rd_val[`CSD_PD_BIT] = r.pd_en;
        rd_val[`CSD_PRESENT_BIT] = r.present;
      end
      `CSD_ADDR_AUX_CTRL: begin
        rd_val[`CSD_PDBIT_BIT] = r.pd_bit;
      end
      default: begin
        rd_val = `CSD_ZERO8;
      end
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.s1 = {card_detect_pin, external_ready, core_fault_in,
                 card_supply_good_in, tick_1k, tick_32k};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.rdata = reg_rd ? rd_val : `CSD_ZERO8;

    // Software writes
    if (wr_ctrl) begin
      // Both select bits land in one write
      next_r.sel = reg_wdata[`CSD_SEL_HI:`CSD_SEL_LO];
      next_r.fault_arm = reg_wdata[`CSD_FAULT_BIT];
      next_r.ready_mode = reg_wdata[`CSD_READY_BIT];
      next_r.pwr_off = reg_wdata[`CSD_PWROFF_BIT];
    end
    if (wr_tmr) begin
      next_r.off_dly = reg_wdata[`CSD_OFFDLY_HI:`CSD_OFFDLY_LO];
      next_r.settle_to = reg_wdata[`CSD_SETTLE_HI:`CSD_SETTLE_LO];
    end
    if (wr_det) begin
      next_r.filt_en = reg_wdata[`CSD_FILT_BIT];
      next_r.det_en = reg_wdata[`CSD_DETEN_BIT];
      next_r.det_pol = reg_wdata[`CSD_POL_BIT];
      next_r.pu_n = reg_wdata[`CSD_PU_BIT];
      next_r.pd_en = reg_wdata[`CSD_PD_BIT];
    end
    if (wr_aux) begin
      next_r.pd_bit = reg_wdata[`CSD_PDBIT_BIT];
    end

    // Card presence filter
    if (!raw) begin
      next_r.present = 1'b0;
      next_r.deb = `CSD_ZERO7;
    end else if (!r.filt_en || r.pd_bit) begin
      // No tick is trusted in power down, so no filter
      next_r.present = 1'b1;
      next_r.deb = `CSD_ZERO7;
    end else if (r.deb == `CSD_DEBOUNCE_TICKS) begin
      next_r.present = 1'b1;
    end else if (t1k) begin
      next_r.deb = r.deb + `CSD_ONE7;
    end

    // Presence change is judged only after the filter has decided
    card_event = next_r.present != r.present;
    emergency = card_event | ~good;

    // Core supply fault beats a software write of select or fault arm
    if (fault_hit) begin
      next_r.fault_arm = 1'b0;
      next_r.sel = `CSD_ZERO2;
    end

    // Power sequencer
    case (r.state)
      csd_pkg::CSD_IDLE: begin
        if (wr_ctrl && !fault_hit &&
            reg_wdata[`CSD_SEL_HI:`CSD_SEL_LO] != `CSD_ZERO2) begin
          next_r.state = csd_pkg::CSD_SETTLE;
          next_r.level = reg_wdata[`CSD_SEL_HI:`CSD_SEL_LO];
          next_r.cnt = r.settle_to;
        end
      end
      csd_pkg::CSD_SETTLE: begin
        if (fault_hit || card_event ||
            next_r.sel == `CSD_ZERO2) begin
          next_r.sel = `CSD_ZERO2;
          // Lines never ran here; the early steps would pulse them on
          next_r.state = csd_pkg::CSD_DEACT_IO;
        end else if (r.ready_mode && good &&
                     (r.settle_to != `CSD_ZERO4 || rdy)) begin
          next_r.state = csd_pkg::CSD_ACTIVE;
        end else if (expired) begin
          // Expiry in either mode ends the attempt
          next_r.sel = `CSD_ZERO2;
          next_r.state = csd_pkg::CSD_DEACT_IO;
        end else if (t32 && r.cnt != `CSD_ZERO4) begin
          next_r.cnt = r.cnt - `CSD_ONE4;
        end
      end
      csd_pkg::CSD_ACTIVE: begin
        if (fault_hit || emergency) begin
          // Hardware clears select; firmware must rewrite it
          next_r.sel = `CSD_ZERO2;
          next_r.state = csd_pkg::CSD_DEACT_RST;
        end else if (next_r.sel == `CSD_ZERO2) begin
          next_r.cnt = r.off_dly;
          next_r.state = (r.off_dly == `CSD_ZERO4) ?
              csd_pkg::CSD_DEACT_RST :
              csd_pkg::CSD_OFF_DELAY;
        end
      end
      csd_pkg::CSD_OFF_DELAY: begin
        if (fault_hit || emergency) begin
          next_r.state = csd_pkg::CSD_DEACT_RST;
        end else if (t32) begin
          next_r.cnt = r.cnt - `CSD_ONE4;
          if (r.cnt == `CSD_ONE4) begin
            next_r.state = csd_pkg::CSD_DEACT_RST;
          end
        end
      end
      csd_pkg::CSD_DEACT_RST: begin
        next_r.state = csd_pkg::CSD_DEACT_CLK;
      end
      csd_pkg::CSD_DEACT_CLK: begin
        next_r.state = csd_pkg::CSD_DEACT_IO;
      end
      csd_pkg::CSD_DEACT_IO: begin
        // Level drops together with the supply switch
        next_r.level = `CSD_ZERO2;
        next_r.state = csd_pkg::CSD_SUPPLY_OFF;
      end
      csd_pkg::CSD_SUPPLY_OFF: begin
        next_r.state = csd_pkg::CSD_IDLE;
      end
      default: begin
        next_r.state = csd_pkg::CSD_IDLE;
      end
    endcase

    // Flags: a set in the read cycle survives the clear
    if (rd_int) begin
      next_r.ev_flag = 1'b0;
      next_r.to_flag = 1'b0;
    end
    if (card_event || (r.state == csd_pkg::CSD_SETTLE &&
        settle_fail)) begin
      next_r.ev_flag = 1'b1;
    end
    if (r.state == csd_pkg::CSD_SETTLE && expired) begin
      next_r.to_flag = 1'b1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.state <= csd_pkg::CSD_IDLE;
      r.off_dly <= `CSD_RST_OFFDLY;
      r.settle_to <= `CSD_RST_SETTLE;
      r.det_en <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = r.rdata;
  assign card_supply_level = r.level;
  // Supply stays up until the I/O step is over
  assign card_supply_on = (r.state != csd_pkg::CSD_IDLE) &&
      (r.state != csd_pkg::CSD_SUPPLY_OFF);
  assign card_rst_n = (r.state == csd_pkg::CSD_ACTIVE) ||
      (r.state == csd_pkg::CSD_OFF_DELAY);
  assign card_clk_enable = card_rst_n ||
      (r.state == csd_pkg::CSD_DEACT_RST);
  assign card_io_enable = card_clk_enable ||
      (r.state == csd_pkg::CSD_DEACT_CLK);
  assign chip_power_off = r.pwr_off;
  assign pullup_enable_n = r.pu_n;
  assign pulldown_enable = r.pd_en;
  assign card_present = r.present;

endmodule
`default_nettype wire

/* csd_top_props.sv */
`default_nettype none
module csd_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [1:0] card_supply_level,
  input wire logic card_supply_on,
  input wire logic card_rst_n,
  input wire logic card_clk_enable,
  input wire logic card_io_enable,
  input wire logic chip_power_off,
  input wire logic pullup_enable_n,
  input wire logic pulldown_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Sequencer and pin checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  act_level_a: assert property (
    $rose(card_supply_on) |-> $past(reg_wr) && $past(reg_addr) == 16'hfe03
    && card_supply_level == $past(reg_wdata[7:6]) && card_supply_level != 0)
    else $error("supply on without select write");
  off_level_a: assert property (
    !card_supply_on |-> card_supply_level == 2'h0)
    else $error("level while supply off");
  deact_order_a: assert property (
    $fell(card_clk_enable) |-> !$past(card_rst_n) && card_io_enable
    ##1 !card_io_enable && card_supply_on ##1 !card_supply_on)
    else $error("deactivation out of order");
  supply_last_a: assert property (
    $fell(card_supply_on) |-> !card_rst_n && !card_clk_enable
    && !card_io_enable && !$past(card_io_enable))
    else $error("supply off before lines");
  clk_supply_a: assert property (
    card_clk_enable |-> card_supply_on)
    else $error("clock without supply");
  io_supply_a: assert property (
    card_io_enable |-> card_supply_on)
    else $error("io without supply");
  pwr_bit_a: assert property (
    reg_wr && reg_addr == 16'hfe03 |=> chip_power_off == $past(reg_wdata[0]))
    else $error("power off bit wrong");
  pull_bits_a: assert property (
    reg_wr && reg_addr == 16'hfe05 |=> pullup_enable_n == $past(reg_wdata[2])
    && pulldown_enable == $past(reg_wdata[1]))
    else $error("pull enables wrong");
endmodule
bind csd_top csd_checker u_chk (.clk, .reset_n, .reg_addr, .reg_wdata,
  .reg_wr, .card_supply_level, .card_supply_on, .card_rst_n,
  .card_clk_enable, .card_io_enable, .chip_power_off, .pullup_enable_n,
  .pulldown_enable);
`default_nettype wire

/* tb_csd_top.sv */
`default_nettype none
module tb_csd_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic tick_32k = 1'b0, tick_1k = 1'b0, core_fault_in = 1'b0;
  logic external_ready = 1'b0, fail = 1'b0, inserted = 1'b0;
  logic card_supply_good_in, card_detect_pin, card_supply_on, card_rst_n;
  logic card_clk_enable, card_io_enable, chip_power_off, pullup_enable_n;
  logic pulldown_enable, card_present;
  logic [1:0] card_supply_level;
  int fail_count = 0, tests_run = 0;
  csd_top DUT (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .tick_32k, .tick_1k, .card_supply_good_in, .core_fault_in,
    .external_ready, .card_detect_pin, .card_supply_level, .card_supply_on,
    .card_rst_n, .card_clk_enable, .card_io_enable, .chip_power_off,
    .pullup_enable_n, .pulldown_enable, .card_present);
  csd_card_model card (.clk, .card_supply_on, .fail, .inserted,
    .card_supply_good_in, .card_detect_pin);
  // ----
  // Tasks
  // ----
  initial forever #12.5 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Ticks run far faster than the real timebases to keep the run short
  task automatic tk(input bit k, input int n);
    repeat (n) begin
      if (k) tick_1k <= 1'b1;
      else tick_32k <= 1'b1;
      cyc(3);
      tick_1k <= 1'b0;
      tick_32k <= 1'b0;
      cyc(3);
    end
  endtask
  task automatic wait_for(input bit off);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if (off ? card_supply_on === 1'b0 : card_rst_n === 1'b1) return;
    end
    fail_count++;
    complete_run();
  endtask
  task automatic act(input logic [7:0] d);
    wr(16'hfe03, 8'h00);
    wr(16'hfe03, d);
  endtask
  task automatic det(input logic [7:0] d);
    wr(16'hfe05, d & 8'hbf);
    wr(16'hfe05, d);
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    cyc(8);
    reset_n <= 1'b1;
    rd(16'hfe03, 8'h00);
    rd(16'hfe04, 8'h0f);
    rd(16'hfe05, 8'h00);
    rd(16'hfe00, 8'h00);
    wr(16'hfe03, 8'h09);
    rd(16'hfe03, 8'h01);
    wr(16'hfe03, 8'h00);
    wr(16'hfe04, 8'h03);
    for (int s = 1; s < 4; s++) begin
      act(8'(s * 64 + 16));
      #1 chk(8'(card_supply_level), 8'(s));
      wait_for(0);
      rd(16'hfe03, 8'(s * 64 + 24));
      wr(16'hfe03, 8'h10);
      wait_for(1);
    end
    wr(16'hfe04, 8'h23);
    act(8'h50);
    wait_for(0);
    wr(16'hfe03, 8'h10);
    cyc(10);
    chk(8'(card_supply_on), 8'h01);
    tk(0, 1);
    chk(8'(card_supply_on), 8'h01);
    tk(0, 1);
    wait_for(1);
    wr(16'hfe04, 8'h02);
    for (int f = 0; f < 2; f++) begin
      fail <= f[0];
      act(8'h40);
      // Let the supply settle so good is seen before expiry when fail is clear
      cyc(12);
      tk(0, 2);
      wait_for(1);
      rd(16'hfe01, f ? 8'h60 : 8'h20);
      rd(16'hfe01, 8'h00);
      rd(16'hfe03, 8'h00);
    end
    fail <= 1'b0;
    wr(16'hfe04, 8'hf3);
    det(8'h48);
    act(8'h50);
    wait_for(0);
    inserted <= 1'b1;
    wait_for(1);
    chk(8'(card_present), 8'h01);
    rd(16'hfe01, 8'h40);
    inserted <= 1'b0;
    cyc(4);
    rd(16'hfe01, 8'h40);
    for (int p = 0; p < 2; p++) begin
      det(p ? 8'h4e : 8'h40);
      cyc(4);
      chk(8'(card_present), 8'(1 - p));
    end
    det(8'hc8);
    inserted <= 1'b1;
    tk(1, 63);
    chk(8'(card_present), 8'h00);
    tk(1, 1);
    chk(8'(card_present), 8'h01);
    inserted <= 1'b0;
    cyc(4);
    chk(8'(card_present), 8'h00);
    wr(16'hfe10, 8'h01);
    inserted <= 1'b1;
    cyc(4);
    chk(8'(card_present), 8'h01);
    inserted <= 1'b0;
    wr(16'hfe10, 8'h00);
    wr(16'hfe04, 8'h00);
    act(8'h50);
    cyc(12);
    chk(8'(card_rst_n), 8'h00);
    external_ready <= 1'b1;
    wait_for(0);
    wr(16'hfe03, 8'h10);
    wait_for(1);
    external_ready <= 1'b0;
    wr(16'hfe04, 8'hf3);
    for (int i = 0; i < 2; i++) begin
      act(i ? 8'h50 : 8'h70);
      wait_for(0);
      if (i) fail <= 1'b1;
      else core_fault_in <= 1'b1;
      cyc(12);
      chk(8'(card_supply_on), 8'h00);
      rd(16'hfe03, 8'h10);
      fail <= 1'b0;
      core_fault_in <= 1'b0;
    end
    complete_run();
  end
  initial begin
    cyc(100000);
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
